// >>> watchdog_pkg.sv
// Constants and types shared by the seeded window watchdog files
package watchdog_pkg;

	// ----------------------------------------
	// Clock and timebase
	// ----------------------------------------
	localparam int CLK_MHZ = 40; // System clock rate in MHz
	localparam int TICK_PERIOD_US = 250; // Timebase step, a quarter millisecond
	localparam int TICK_CYCLES = TICK_PERIOD_US * CLK_MHZ; // Clock cycles per timebase step
	localparam int TIMER_W = 18; // Width of the quarter-ms period timer
	localparam logic [TIMER_W-1:0] QUARTERS_PER_MS = 18'h00004; // Timebase steps per millisecond

	// ----------------------------------------
	// Seed and response
	// ----------------------------------------
	localparam logic [7:0] SEED_RESET = 8'hA5; // Seed after power-up and hard reset
	localparam logic [7:0] SEED_ZERO = 8'h00; // Rejected seed in dynamic mode
	localparam logic [7:0] SEED_ONES = 8'hFF; // Rejected seed in dynamic mode
	localparam logic [7:0] SEED_TAPS = 8'hB8; // Right-shift feedback taps of the seed sequence

	// ----------------------------------------
	// Counters
	// ----------------------------------------
	localparam logic [3:0] BAD_STEP_UP = 4'h2; // Bad refresh adds this
	localparam logic [2:0] BAD_STEP_DOWN = 3'h1; // Good refresh subtracts this
	localparam logic [2:0] BAD_COUNT_MAX = 3'h7; // Bad counter saturates here
	localparam logic [2:0] DEV_MODE_LIMIT = 3'h0; // Limit that disables watchdog resets
	localparam logic [2:0] FAULT_CLEAR_OFF = 3'h0; // Interval that disables fault clearing
	localparam logic [3:0] RESET_COUNT_MAX = 4'hF; // Reset counter saturates here

	// ----------------------------------------
	// Period phases
	// ----------------------------------------
	typedef enum logic [1:0] {
		PHASE_IDLE = 2'b00,
		PHASE_CLOSED = 2'b01,
		PHASE_OPEN = 2'b10
	} phase_type;

endpackage

// >>> seed_if.sv
// Interface carrying seed load and step requests to the seed generator
`timescale 1ns/1ps
interface seed_if;
	logic loadStb; // Load loadVal into the seed
	logic [7:0] loadVal; // Value for a load
	logic stepStb; // Advance to the next dynamic seed
	logic [7:0] seed; // Current seed

	modport gen (input loadStb, input loadVal, input stepStb, output seed);
	modport ctl (output loadStb, output loadVal, output stepStb, input seed);
endinterface

// >>> watchdog_tick_divider.sv
// Divider making the quarter-millisecond timebase enable
`timescale 1ns/1ps
module watchdog_tick_divider #(
	parameter int TICK_CYCLES = watchdog_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	output logic tickEn
);

	// ----------------------------------------
	// Cycle counter
	// ----------------------------------------
	logic [15:0] countQ; // Cycles since last tick
	logic [15:0] countD;
	logic tickD;

	// Next count, restarted by clear so a period starts aligned
	always_comb begin
		countD = countQ + 16'h0001;
		tickD = 1'b0;
		if (clear) begin
			countD = 16'h0000;
		end else if (countQ == 16'(TICK_CYCLES - 1)) begin
			countD = 16'h0000;
			tickD = 1'b1;
		end
	end

	// Register count and tick
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			countQ <= 16'h0000;
			tickEn <= 1'b0;
		end else begin
			countQ <= countD;
			tickEn <= tickD;
		end
	end

endmodule // watchdog_tick_divider

// >>> watchdog_seed_gen.sv
// Seed register with static load and dynamic sequence stepping
`timescale 1ns/1ps
module watchdog_seed_gen (
	input wire logic clk,
	input wire logic rst_n,
	seed_if.gen sif
);

	// ----------------------------------------
	// Seed register
	// ----------------------------------------
	logic [7:0] seedQ; // Current seed
	logic [7:0] seedD;

	// Next seed: a load wins over a step
	always_comb begin
		seedD = seedQ;
		if (sif.loadStb) begin
			seedD = sif.loadVal;
		end else if (sif.stepStb) begin
			// Galois shift; never reaches zero from a nonzero seed
			seedD = {1'b0, seedQ[7:1]} ^ (seedQ[0] ? watchdog_pkg::SEED_TAPS : 8'h00);
		end
	end

	// Register the seed; power-up value fixed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seedQ <= watchdog_pkg::SEED_RESET;
		end else begin
			seedQ <= seedD;
		end
	end

	assign sif.seed = seedQ;

endmodule // watchdog_seed_gen

// >>> seeded_window_watchdog.sv
// Seeded window watchdog: timer, response check, counters and flags
//
// Contract
// - Enable bit, nonvolatile default, host writable
// - Inactive outside run and monitored standby
// - Static or dynamic seed per version
// - Static seed A5 at power-up, hard reset
// - Dynamic seed steps on every refresh attempt without a seed load or hard reset in the same cycle
// - Soft reset leaves the seed alone
// - Dynamic mode rejects 00/FF seed, raises error
// - Valid response is inverted seed, open window
// - Bad refresh sets error flag, interrupt
// - Timer restarts after every refresh event
// - Duration is two to sel milliseconds
// - Timer starts after reset pin release
// - Duration write restarts the timer
// - Window ratio closes first part of period
// - Closed-window or missing service counts bad
// - Bad counter plus two, minus one
// - Count at limit: hard reset, reset count
// - Bad limit default from nonvolatile setting
// - Limit zero means no watchdog reset
// - Good streak counts up, clears on bad
// - N good refreshes decrement fault counters
// - Fault interval default from nonvolatile setting
`timescale 1ns/1ps
module seeded_window_watchdog #(
	parameter bit DYNAMIC_SEED = 1'b0, // Version select: 0 static, 1 dynamic
	parameter int TICK_CYCLES = watchdog_pkg::TICK_CYCLES // Cycles per quarter millisecond
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic systemOn, // Run or monitored standby
	input wire logic resetPinReleased, // Reset output pin released
	input wire logic hardResetIn, // Hard reset condition present
	input wire logic nvWatchdogEnable,
	input wire logic [3:0] nvTimerDurationSel,
	input wire logic [1:0] nvWindowRatioSel,
	input wire logic [2:0] nvBadRefreshLimit,
	input wire logic [2:0] nvFaultClearInterval,
	input wire logic enableWrStb,
	input wire logic enableWrData,
	input wire logic seedWrStb,
	input wire logic [7:0] seedWrData,
	input wire logic responseWrStb,
	input wire logic [7:0] responseWrData,
	input wire logic durationWrStb,
	input wire logic [3:0] durationWrData,
	input wire logic limitWrStb,
	input wire logic [2:0] limitWrData,
	input wire logic faultClearWrStb,
	input wire logic [2:0] faultClearWrData,
	input wire logic errorFlagClr, // Write-one-to-clear of the error flag
	input wire logic errorMask, // Masks the error interrupt
	output logic watchdogEnableBit,
	output logic [7:0] watchdogSeed,
	output logic [3:0] timerDurationSel,
	output logic [2:0] badRefreshLimit,
	output logic [2:0] faultClearInterval,
	output logic [2:0] badRefreshCount,
	output logic [2:0] goodRefreshStreak,
	output logic [3:0] resetEventCount,
	output logic watchdogErrorFlag,
	output logic interruptOutN,
	output logic goodRefreshEvent,
	output logic badRefreshEvent,
	output logic hardResetReq,
	output logic faultCountDecStb
);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------

	// Period length in quarter milliseconds
	function automatic logic [watchdog_pkg::TIMER_W-1:0] periodQuarters(input logic [3:0] sel);
		periodQuarters = watchdog_pkg::QUARTERS_PER_MS << sel;
	endfunction

	// Closed part: one quarter of the period per ratio step
	function automatic logic [watchdog_pkg::TIMER_W-1:0] closedQuarters(input logic [3:0] sel,
		input logic [1:0] ratio);
		logic [watchdog_pkg::TIMER_W-1:0] unit;
		unit = watchdog_pkg::TIMER_W'(18'h00001 << sel);
		closedQuarters = watchdog_pkg::TIMER_W'(unit * ratio);
	endfunction

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	seed_if sif (); // Seed control link
	logic tickEn; // Quarter-ms enable
	logic restart; // Period restart request

	watchdog_tick_divider #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_divider (
		.clk(clk),
		.rst_n(rst_n),
		.clear(restart),
		.tickEn(tickEn)
	);

	watchdog_seed_gen u_seed (
		.clk(clk),
		.rst_n(rst_n),
		.sif(sif)
	);

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	logic nvLoadedQ, nvLoadedD; // Nonvolatile defaults taken
	logic enableQ, enableD; // Software enable
	logic [3:0] durationQ, durationD; // Duration select
	logic [1:0] windowQ, windowD; // Window ratio, fixed after load
	logic [2:0] limitQ, limitD; // Bad refresh limit
	logic [2:0] fciQ, fciD; // Fault clear interval
	watchdog_pkg::phase_type phaseQ, phaseD; // Period phase
	logic [watchdog_pkg::TIMER_W-1:0] timerQ, timerD; // Quarters elapsed
	logic [2:0] badQ, badD; // Bad refresh counter
	logic [2:0] streakQ, streakD; // Consecutive good count
	logic [3:0] resetCntQ, resetCntD; // Watchdog reset count
	logic errorQ, errorD; // Sticky error flag
	logic intNQ, intND; // Interrupt pin level
	logic goodQ, goodD; // Good event pulse
	logic badEvQ, badEvD; // Bad event pulse
	logic hardQ, hardD; // Hard reset request pulse
	logic decQ, decD; // Fault decrement pulse

	// ----------------------------------------
	// Event decode
	// ----------------------------------------
	logic active; // Watchdog allowed to run
	logic attempt; // Response written while running
	logic goodHit; // Valid response
	logic expire; // Period ran out
	logic badHit; // Any bad refresh
	logic seedReject; // Illegal dynamic seed
	logic seedLoad; // Accepted seed write
	logic [3:0] badSum; // Bad count plus step

	// Decode refresh events from writes and the timer
	always_comb begin
		active = nvLoadedQ && enableQ && systemOn && resetPinReleased;
		attempt = responseWrStb && active;
		goodHit = attempt && (responseWrData == ~sif.seed) && (phaseQ == watchdog_pkg::PHASE_OPEN);
		expire = active && tickEn && (phaseQ != watchdog_pkg::PHASE_IDLE)
			&& (timerQ + 18'h00001 >= periodQuarters(durationQ));
		badHit = (attempt && !goodHit) || (expire && !attempt);
		seedReject = seedWrStb && DYNAMIC_SEED
			&& (seedWrData == watchdog_pkg::SEED_ZERO || seedWrData == watchdog_pkg::SEED_ONES);
		seedLoad = seedWrStb && !seedReject;
		badSum = {1'b0, badQ} + watchdog_pkg::BAD_STEP_UP;
	end

	// ----------------------------------------
	// Seed control
	// ----------------------------------------

	// Hard reset reloads the default; nothing here reacts to soft reset
	always_comb begin
		sif.loadStb = hardResetIn || seedLoad;
		sif.loadVal = hardResetIn ? watchdog_pkg::SEED_RESET : seedWrData;
		sif.stepStb = DYNAMIC_SEED && attempt;
	end

	// ----------------------------------------
	// Configuration next state
	// ----------------------------------------
	always_comb begin
		nvLoadedD = 1'b1;
		enableD = enableQ;
		durationD = durationQ;
		windowD = windowQ;
		limitD = limitQ;
		fciD = fciQ;
		if (!nvLoadedQ) begin
			// First cycle after reset: take nonvolatile defaults
			enableD = nvWatchdogEnable;
			durationD = nvTimerDurationSel;
			windowD = nvWindowRatioSel;
			limitD = nvBadRefreshLimit;
			fciD = nvFaultClearInterval;
		end else begin
			// Enable writes only take effect while on; duration, limit and fault clear writes always do
			if (enableWrStb && systemOn) begin
				enableD = enableWrData;
			end
			if (durationWrStb) begin
				durationD = durationWrData;
			end
			if (limitWrStb) begin
				limitD = limitWrData;
			end
			if (faultClearWrStb) begin
				fciD = faultClearWrData;
			end
		end
	end

	// ----------------------------------------
	// Period timer next state
	// ----------------------------------------
	always_comb begin
		phaseD = phaseQ;
		timerD = timerQ;
		restart = 1'b0;
		if (!active) begin
			// Held off while disabled or out of the on states
			phaseD = watchdog_pkg::PHASE_IDLE;
			timerD = '0;
		end else if (phaseQ == watchdog_pkg::PHASE_IDLE || goodHit || badHit
			|| (durationWrStb && systemOn)) begin
			// New period after events and duration changes
			restart = 1'b1;
			timerD = '0;
			phaseD = (closedQuarters(durationD, windowQ) == '0)
				? watchdog_pkg::PHASE_OPEN : watchdog_pkg::PHASE_CLOSED;
		end else if (tickEn) begin
			// Advance; open once the closed part is over
			timerD = timerQ + 18'h00001;
			if (phaseQ == watchdog_pkg::PHASE_CLOSED
				&& timerD >= closedQuarters(durationQ, windowQ)) begin
				phaseD = watchdog_pkg::PHASE_OPEN;
			end
		end
	end

	// ----------------------------------------
	// Counters and flags next state
	// ----------------------------------------
	always_comb begin
		badD = badQ;
		streakD = streakQ;
		resetCntD = resetCntQ;
		goodD = goodHit;
		badEvD = badHit;
		hardD = 1'b0;
		decD = 1'b0;
		if (badHit) begin
			streakD = '0;
			if (limitQ != watchdog_pkg::DEV_MODE_LIMIT && badSum >= {1'b0, limitQ}) begin
				// Limit reached: request reset, counter starts over
				hardD = 1'b1;
				badD = '0;
				if (resetCntQ != watchdog_pkg::RESET_COUNT_MAX) begin
					resetCntD = resetCntQ + 4'h1;
				end
			end else if (badSum > {1'b0, watchdog_pkg::BAD_COUNT_MAX}) begin
				// Development mode only (limit zero): saturate
				badD = watchdog_pkg::BAD_COUNT_MAX;
			end else begin
				badD = badSum[2:0];
			end
		end else if (goodHit) begin
			if (badQ != '0) begin
				badD = badQ - watchdog_pkg::BAD_STEP_DOWN;
			end
			if (fciQ != watchdog_pkg::FAULT_CLEAR_OFF && streakQ + 3'h1 >= fciQ) begin
				// Enough good refreshes: decrement and start over
				decD = 1'b1;
				streakD = '0;
				if (resetCntQ != '0) begin
					resetCntD = resetCntQ - 4'h1;
				end
			end else if (streakQ != 3'h7) begin
				streakD = streakQ + 3'h1;
			end
		end
		// Set wins over a clear in the same cycle
		errorD = (errorQ && !errorFlagClr) || badHit || seedReject;
		intND = !(errorD && !errorMask);
	end

	// ----------------------------------------
	// Register all state
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nvLoadedQ <= 1'b0;
			enableQ <= 1'b0;
			durationQ <= 4'h0;
			windowQ <= 2'h0;
			limitQ <= 3'h0;
			fciQ <= 3'h0;
			phaseQ <= watchdog_pkg::PHASE_IDLE;
			timerQ <= '0;
			badQ <= 3'h0;
			streakQ <= 3'h0;
			resetCntQ <= 4'h0;
			errorQ <= 1'b0;
			intNQ <= 1'b1;
			goodQ <= 1'b0;
			badEvQ <= 1'b0;
			hardQ <= 1'b0;
			decQ <= 1'b0;
		end else begin
			nvLoadedQ <= nvLoadedD;
			enableQ <= enableD;
			durationQ <= durationD;
			windowQ <= windowD;
			limitQ <= limitD;
			fciQ <= fciD;
			phaseQ <= phaseD;
			timerQ <= timerD;
			badQ <= badD;
			streakQ <= streakD;
			resetCntQ <= resetCntD;
			errorQ <= errorD;
			intNQ <= intND;
			goodQ <= goodD;
			badEvQ <= badEvD;
			hardQ <= hardD;
			decQ <= decD;
		end
	end

	// ----------------------------------------
	// Outputs, all from flip-flops
	// ----------------------------------------
	assign watchdogEnableBit = enableQ;
	assign watchdogSeed = sif.seed;
	assign timerDurationSel = durationQ;
	assign badRefreshLimit = limitQ;
	assign faultClearInterval = fciQ;
	assign badRefreshCount = badQ;
	assign goodRefreshStreak = streakQ;
	assign resetEventCount = resetCntQ;
	assign watchdogErrorFlag = errorQ;
	assign interruptOutN = intNQ;
	assign goodRefreshEvent = goodQ;
	assign badRefreshEvent = badEvQ;
	assign hardResetReq = hardQ;
	assign faultCountDecStb = decQ;

endmodule // seeded_window_watchdog

// >>> watchdog_host_model.sv
// Host model that services the watchdog by writing inverted seeds
`timescale 1ns/1ps
module watchdog_host_model #(
	parameter bit DYNAMIC_SEED = 1'b1 // Host predicts stepping seeds
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go, // Start one service write
	input wire logic corrupt, // Send a wrong key
	input wire logic resync, // Reload tracked seed from readback
	input wire logic [7:0] seedIn, // Seed readback
	output logic responseWrStb,
	output logic [7:0] responseWrData
);
	logic [7:0] trackQ; // Locally predicted seed

	// ----------------------------------------
	// Service writes and seed tracking
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trackQ <= watchdog_pkg::SEED_RESET;
			responseWrStb <= 1'b0;
			responseWrData <= 8'h00;
		end else begin
			responseWrStb <= go;
			if (go) begin
				responseWrData <= corrupt ? (trackQ ^ 8'h5C) : ~trackQ;
				if (DYNAMIC_SEED) begin
					trackQ <= {1'b0, trackQ[7:1]} ^ (trackQ[0] ? watchdog_pkg::SEED_TAPS : 8'h00);
				end
			end else begin
				responseWrData <= ~responseWrData; // Idle bus data toggles every cycle, so it holds the last written value in alternate cycles
			end
			if (resync) begin
				trackQ <= seedIn;
			end
		end
	end
endmodule // watchdog_host_model

// >>> seeded_window_watchdog_chk.sv
// Concurrent checks on the seeded window watchdog ports
`timescale 1ns/1ps
module seeded_window_watchdog_chk #(
	parameter bit DYNAMIC_SEED = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic systemOn,
	input wire logic resetPinReleased,
	input wire logic hardResetIn,
	input wire logic seedWrStb,
	input wire logic [7:0] seedWrData,
	input wire logic responseWrStb,
	input wire logic [7:0] responseWrData,
	input wire logic errorMask,
	input wire logic watchdogEnableBit,
	input wire logic [7:0] watchdogSeed,
	input wire logic [2:0] badRefreshLimit,
	input wire logic [2:0] badRefreshCount,
	input wire logic [2:0] goodRefreshStreak,
	input wire logic [3:0] resetEventCount,
	input wire logic watchdogErrorFlag,
	input wire logic interruptOutN,
	input wire logic goodRefreshEvent,
	input wire logic badRefreshEvent,
	input wire logic hardResetReq,
	input wire logic faultCountDecStb
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// Event causes and reactions
	// ----------------------------------------
	wrong_key_a: assert property (responseWrStb && responseWrData != ~watchdogSeed && watchdogEnableBit && systemOn
		&& resetPinReleased |=> badRefreshEvent) else $error("wrong key not reported bad");
	asleep_a: assert property (!systemOn |=> !goodRefreshEvent && !badRefreshEvent)
		else $error("refresh event while system asleep");
	bad_irq_a: assert property (badRefreshEvent && !errorMask && $stable(errorMask) |-> watchdogErrorFlag && !interruptOutN)
		else $error("bad refresh without flag and interrupt");
	streak_clear_a: assert property (badRefreshEvent |-> goodRefreshStreak == 3'h0)
		else $error("streak not cleared on bad refresh");
	streak_up_a: assert property (goodRefreshEvent && !faultCountDecStb && $past(goodRefreshStreak) != 3'h7
		|-> goodRefreshStreak == $past(goodRefreshStreak) + 3'h1) else $error("streak not incremented");
	bad_down_a: assert property (goodRefreshEvent |-> badRefreshCount ==
		(($past(badRefreshCount) == 3'h0) ? 3'h0 : $past(badRefreshCount) - 3'h1)) else $error("bad count not decremented");
	bad_up_a: assert property (badRefreshEvent && !hardResetReq |-> badRefreshCount ==
		(($past(badRefreshCount) > 3'h5) ? 3'h7 : $past(badRefreshCount) + 3'h2)) else $error("bad count not raised by two");
	reset_cause_a: assert property (hardResetReq |-> badRefreshEvent && badRefreshLimit != 3'h0)
		else $error("watchdog reset without cause");
	reset_count_a: assert property (hardResetReq && $past(resetEventCount) != 4'hF
		|-> resetEventCount == $past(resetEventCount) + 4'h1) else $error("reset count not incremented");
	clear_streak_a: assert property (faultCountDecStb |-> goodRefreshEvent && goodRefreshStreak == 3'h0)
		else $error("fault decrement without good refresh or streak restart");
	bad_seed_a: assert property (DYNAMIC_SEED && seedWrStb && (seedWrData == 8'h00 || seedWrData == 8'hFF)
		&& !responseWrStb && !hardResetIn |=> watchdogErrorFlag && $stable(watchdogSeed)) else $error("invalid seed taken");
endmodule // seeded_window_watchdog_chk

bind seeded_window_watchdog seeded_window_watchdog_chk #(.DYNAMIC_SEED(DYNAMIC_SEED)) u_chk (.clk(clk), .rst_n(rst_n),
	.systemOn(systemOn), .resetPinReleased(resetPinReleased), .hardResetIn(hardResetIn), .seedWrStb(seedWrStb),
	.seedWrData(seedWrData), .responseWrStb(responseWrStb), .responseWrData(responseWrData), .errorMask(errorMask),
	.watchdogEnableBit(watchdogEnableBit), .watchdogSeed(watchdogSeed), .badRefreshLimit(badRefreshLimit),
	.badRefreshCount(badRefreshCount), .goodRefreshStreak(goodRefreshStreak), .resetEventCount(resetEventCount),
	.watchdogErrorFlag(watchdogErrorFlag), .interruptOutN(interruptOutN), .goodRefreshEvent(goodRefreshEvent),
	.badRefreshEvent(badRefreshEvent), .hardResetReq(hardResetReq), .faultCountDecStb(faultCountDecStb));

// >>> testbench.sv
// Self-checking testbench for the seeded window watchdog
`timescale 1ns/1ps
module testbench;
	logic clk, rst_n, systemOn, hardResetIn, enableWrStb, enableWrData, seedWrStb, limitWrStb, errorFlagClr, errorMask;
	logic [7:0] seedWrData;
	logic [2:0] limitWrData;
	logic go, corrupt, resync, responseWrStb, gotGood, gotBad, gotDec, gotHard;
	logic [7:0] responseWrData, watchdogSeed;
	logic watchdogEnableBit, watchdogErrorFlag, interruptOutN, goodRefreshEvent, badRefreshEvent;
	logic hardResetReq, faultCountDecStb;
	logic [3:0] timerDurationSel, resetEventCount;
	logic [2:0] badRefreshLimit, faultClearInterval, badRefreshCount, goodRefreshStreak;
	logic pinRel, nvEn, durationWrStb, faultClearWrStb; // Pin level, nonvolatile enable, extra write strobes
	logic [3:0] nvDur, durationWrData;
	logic [2:0] nvLim, nvFci, faultClearWrData;
	logic [1:0] nvWin;
	int errors = 0, tests_run = 0, cycles = 0, bc = 0, st = 0, rc = 0, lim = 0, fci = 2, k;
	logic [7:0] expSeed = 8'hA5;
	integer rngSeed = 32'hC8B43746;

	// ----------------------------------------
	// Design, host and clock
	// ----------------------------------------
	seeded_window_watchdog #(.DYNAMIC_SEED(1'b1), .TICK_CYCLES(4)) u_seeded_window_watchdog (.clk(clk), .rst_n(rst_n),
		.systemOn(systemOn), .resetPinReleased(pinRel), .hardResetIn(hardResetIn), .nvWatchdogEnable(nvEn),
		.nvTimerDurationSel(nvDur), .nvWindowRatioSel(nvWin), .nvBadRefreshLimit(nvLim), .nvFaultClearInterval(nvFci),
		.enableWrStb(enableWrStb), .enableWrData(enableWrData), .seedWrStb(seedWrStb), .seedWrData(seedWrData),
		.responseWrStb(responseWrStb), .responseWrData(responseWrData), .durationWrStb(durationWrStb),
		.durationWrData(durationWrData), .limitWrStb(limitWrStb), .limitWrData(limitWrData),
		.faultClearWrStb(faultClearWrStb), .faultClearWrData(faultClearWrData),
		.errorFlagClr(errorFlagClr), .errorMask(errorMask), .watchdogEnableBit(watchdogEnableBit),
		.watchdogSeed(watchdogSeed), .timerDurationSel(timerDurationSel), .badRefreshLimit(badRefreshLimit),
		.faultClearInterval(faultClearInterval), .badRefreshCount(badRefreshCount), .goodRefreshStreak(goodRefreshStreak),
		.resetEventCount(resetEventCount), .watchdogErrorFlag(watchdogErrorFlag), .interruptOutN(interruptOutN),
		.goodRefreshEvent(goodRefreshEvent), .badRefreshEvent(badRefreshEvent), .hardResetReq(hardResetReq),
		.faultCountDecStb(faultCountDecStb));
	watchdog_host_model #(.DYNAMIC_SEED(1'b1)) u_watchdog_host_model (.clk(clk), .rst_n(rst_n), .go(go),
		.corrupt(corrupt), .resync(resync), .seedIn(watchdogSeed), .responseWrStb(responseWrStb),
		.responseWrData(responseWrData));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			close_out();
		end
	end

	// ----------------------------------------
	// Compare, expectation and drive tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [7:0] nextSeed(input logic [7:0] s);
		return {1'b0, s[7:1]} ^ (s[0] ? 8'hB8 : 8'h00);
	endfunction
	// Poll for a refresh event, capturing the pulses of that cycle
	task automatic waitEvt(input int n);
		{gotGood, gotBad, gotDec, gotHard} = 4'h0;
		repeat (n) begin
			@(negedge clk);
			if (goodRefreshEvent === 1'b1 || badRefreshEvent === 1'b1) begin
				{gotGood, gotBad, gotDec, gotHard} = {goodRefreshEvent, badRefreshEvent, faultCountDecStb, hardResetReq};
				break;
			end
		end
	endtask
	task automatic serve(input logic bad, input int dly);
		repeat (dly) @(posedge clk);
		go <= 1'b1;
		corrupt <= bad;
		@(posedge clk);
		go <= 1'b0;
		waitEvt(6);
	endtask
	// Update the count model for one event and compare every result
	task automatic expectEvt(input bit good, input bit stepped);
		bit dec, hard;
		chk("good event", 8'(good), 8'(gotGood));
		chk("bad event", 8'(!good), 8'(gotBad));
		if (stepped) expSeed = nextSeed(expSeed);
		dec = 0;
		hard = 0;
		if (good) begin
			bc = (bc == 0) ? 0 : bc - 1;
			st++;
			dec = (st >= fci);
			if (dec) {st, rc} = {32'd0, (rc == 0) ? 32'd0 : rc - 1};
		end else begin
			st = 0;
			hard = (lim != 0) && (bc + 2 >= lim);
			if (hard) {bc, rc} = {32'd0, (rc == 15) ? 32'd15 : rc + 1};
			else bc = (bc + 2 > 7) ? 7 : bc + 2;
			chk("error flag", 8'h01, 8'(watchdogErrorFlag));
			chk("interrupt pin", 8'(errorMask), 8'(interruptOutN));
		end
		chk("seed", expSeed, watchdogSeed);
		chk("bad count", 8'(bc), 8'(badRefreshCount));
		chk("streak", 8'(st), 8'(goodRefreshStreak));
		chk("reset count", 8'(rc), 8'(resetEventCount));
		chk("fault decrement", 8'(dec), 8'(gotDec));
		chk("watchdog reset", 8'(hard), 8'(gotHard));
	endtask
	// One-cycle register write: 0 enable, 1 seed, 2 limit, 3 flag clear, 4 duration, 5 fault clear
	task automatic wrReg(input int r, input logic [7:0] v);
		@(posedge clk);
		enableWrStb <= (r == 0);
		seedWrStb <= (r == 1);
		limitWrStb <= (r == 2);
		errorFlagClr <= (r == 3);
		durationWrStb <= (r == 4);
		faultClearWrStb <= (r == 5);
		{enableWrData, seedWrData, limitWrData, durationWrData, faultClearWrData} <= {v[0], v, v[2:0], v[3:0], v[2:0]};
		@(posedge clk);
		{enableWrStb, seedWrStb, limitWrStb, errorFlagClr, durationWrStb, faultClearWrStb} <= 6'h00;
		@(negedge clk);
	endtask
	// Random mix of good, wrong-key and too-early services
	task automatic randomRun(input int n);
		repeat (n) begin
			k = $unsigned($random(rngSeed)) % 4;
			serve(k == 2, (k == 3) ? 2 : 18 + $unsigned($random(rngSeed)) % 8);
			expectEvt(k < 2, 1);
		end
	endtask
	task automatic close_out();
		if (errors == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst_n, systemOn, hardResetIn, enableWrStb, enableWrData, seedWrStb, limitWrStb, errorFlagClr} = 8'h40;
		{errorMask, go, corrupt, resync, seedWrData, limitWrData, pinRel, durationWrStb, durationWrData} = 21'h0;
		{nvEn, nvDur, nvWin, nvLim, nvFci, faultClearWrStb, faultClearWrData} = {1'b1, 4'h1, 2'h2, 3'h0, 3'h2, 4'h0};
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(negedge clk);
		chk("reset seed", 8'hA5, watchdogSeed);
		chk("enable default", 8'h01, 8'(watchdogEnableBit));
		chk("duration default", 8'h01, 8'(timerDurationSel));
		chk("limit default", 8'h00, 8'(badRefreshLimit));
		chk("clear default", 8'h02, 8'(faultClearInterval));
		waitEvt(45);
		chk("held for pin", 8'h00, 8'({gotGood, gotBad}));
		pinRel <= 1'b1;
		randomRun(12);
		wrReg(5, 8'h03);
		fci = 3;
		chk("clear written", 8'h03, 8'(faultClearInterval));
		wrReg(2, 8'h04);
		lim = 4;
		randomRun(14);
		waitEvt(40);
		expectEvt(0, 0);
		errorMask <= 1'b1;
		@(negedge clk);
		chk("masked pin", 8'h01, 8'(interruptOutN));
		wrReg(3, 8'h01);
		chk("flag cleared", 8'h00, 8'(watchdogErrorFlag));
		wrReg(1, 8'h00);
		chk("zero seed", expSeed, watchdogSeed);
		chk("zero seed flag", 8'h01, 8'(watchdogErrorFlag));
		wrReg(1, 8'h3C);
		expSeed = 8'h3C;
		chk("written seed", 8'h3C, watchdogSeed);
		resync <= 1'b1;
		@(posedge clk);
		resync <= 1'b0;
		waitEvt(40);
		expectEvt(0, 0);
		serve(0, 20);
		expectEvt(1, 1);
		repeat (24) @(posedge clk);
		wrReg(4, 8'h01);
		serve(0, 20);
		expectEvt(1, 1);
		wrReg(0, 8'h00);
		waitEvt(45);
		chk("disabled idle", 8'h00, 8'({gotGood, gotBad}));
		wrReg(0, 8'h01);
		systemOn <= 1'b0;
		wrReg(0, 8'h00);
		chk("enable refused", 8'h01, 8'(watchdogEnableBit));
		waitEvt(45);
		chk("asleep idle", 8'h00, 8'({gotGood, gotBad}));
		@(posedge clk);
		hardResetIn <= 1'b1;
		@(posedge clk);
		hardResetIn <= 1'b0;
		@(negedge clk);
		chk("hard reset seed", 8'hA5, watchdogSeed);
		close_out();
	end
endmodule // testbench
